// [hdl/hdsc_i2c_slave.sv]
// two-wire serial slave with sub-address and auto-increment access
`timescale 1ns/1ps
`default_nettype none
module hdsc_i2c_slave (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclLevel,
	input wire logic sdaLevel,
	input wire logic [6:0] ownAddr,
	output logic sdaPullLow,
	hdsc_reg_if.master regPort
);
	hdsc_pkg::hdsc_i2c_state_type state_reg;
	hdsc_pkg::hdsc_i2c_state_type afterAck_reg;
	logic sclPrev_reg;
	logic sdaPrev_reg;
	logic [7:0] shift_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] idx_reg;
	logic [7:0] wrIdx_reg;
	logic [7:0] wrData_reg;
	logic wrEn_reg;
	logic drive_reg;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic byteDone;

	// bus conditions from the filtered line levels
	assign sclRise = sclLevel & ~sclPrev_reg;
	assign sclFall = ~sclLevel & sclPrev_reg;
	assign startSeen = sclLevel & sclPrev_reg & sdaPrev_reg & ~sdaLevel;
	assign stopSeen = sclLevel & sclPrev_reg & ~sdaPrev_reg & sdaLevel;
	assign byteDone = (bitCnt_reg == 4'h8);
	assign sdaPullLow = drive_reg;
	assign regPort.wrEn = wrEn_reg;
	assign regPort.wrIdx = wrIdx_reg;
	assign regPort.wrData = wrData_reg;
	assign regPort.rdIdx = idx_reg;

	// previous line levels for edge and condition detection
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclPrev_reg <= sclLevel;
			sdaPrev_reg <= sdaLevel;
		end
	end

	// byte engine: sample on scl rise, change sda on scl fall
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= hdsc_pkg::I2C_IDLE;
			afterAck_reg <= hdsc_pkg::I2C_SUB;
			shift_reg <= 8'h00;
			bitCnt_reg <= 4'h0;
			idx_reg <= 8'h00;
			wrIdx_reg <= 8'h00;
			wrData_reg <= 8'h00;
			wrEn_reg <= 1'b0;
			drive_reg <= 1'b0;
		end else begin
			wrEn_reg <= 1'b0;
			if (stopSeen) begin
				state_reg <= hdsc_pkg::I2C_IDLE;
				drive_reg <= 1'b0;
			end else if (startSeen) begin
				state_reg <= hdsc_pkg::I2C_ADDR;
				bitCnt_reg <= 4'h0;
				drive_reg <= 1'b0;
			end else if (sclRise) begin
				unique case (state_reg)
					hdsc_pkg::I2C_ADDR, hdsc_pkg::I2C_SUB,
					hdsc_pkg::I2C_WDATA: begin
						shift_reg <= {shift_reg[6:0], sdaLevel};
						bitCnt_reg <= bitCnt_reg + 4'h1;
					end
					hdsc_pkg::I2C_RDATA: bitCnt_reg <= bitCnt_reg + 4'h1;
					hdsc_pkg::I2C_MACK: begin
						if (sdaLevel) begin
							state_reg <= hdsc_pkg::I2C_IDLE; // no ack ends read
						end else begin
							idx_reg <= idx_reg + 8'h01; // burst read advances
						end
					end
					hdsc_pkg::I2C_IDLE, hdsc_pkg::I2C_ACK: ;
				endcase
			end else if (sclFall) begin
				unique case (state_reg)
					hdsc_pkg::I2C_ADDR: begin
						if (byteDone && shift_reg[7:1] == ownAddr) begin // [RULE8]
							state_reg <= hdsc_pkg::I2C_ACK;
							drive_reg <= 1'b1;
							afterAck_reg <= shift_reg[0] ? hdsc_pkg::I2C_RDATA :
								hdsc_pkg::I2C_SUB; // [RULE13]
						end else if (byteDone) begin
							state_reg <= hdsc_pkg::I2C_IDLE;
						end
					end
					hdsc_pkg::I2C_SUB: begin
						if (byteDone) begin
							idx_reg <= shift_reg; // [RULE13]
							state_reg <= hdsc_pkg::I2C_ACK;
							drive_reg <= 1'b1;
							afterAck_reg <= hdsc_pkg::I2C_WDATA;
						end
					end
					hdsc_pkg::I2C_WDATA: begin
						if (byteDone) begin
							wrEn_reg <= 1'b1;
							wrIdx_reg <= idx_reg;
							wrData_reg <= shift_reg;
							idx_reg <= idx_reg + 8'h01; // [RULE13]
							state_reg <= hdsc_pkg::I2C_ACK;
							drive_reg <= 1'b1;
							afterAck_reg <= hdsc_pkg::I2C_WDATA;
						end
					end
					hdsc_pkg::I2C_ACK, hdsc_pkg::I2C_MACK: begin
						bitCnt_reg <= 4'h0;
						if (state_reg == hdsc_pkg::I2C_MACK ||
							afterAck_reg == hdsc_pkg::I2C_RDATA) begin
							state_reg <= hdsc_pkg::I2C_RDATA;
							shift_reg <= regPort.rdData;
							drive_reg <= ~regPort.rdData[7];
						end else begin
							state_reg <= afterAck_reg;
							drive_reg <= 1'b0;
						end
					end
					hdsc_pkg::I2C_RDATA: begin
						if (byteDone) begin
							drive_reg <= 1'b0; // release for master ack
							state_reg <= hdsc_pkg::I2C_MACK;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							drive_reg <= ~shift_reg[6];
						end
					end
					hdsc_pkg::I2C_IDLE: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_addr_reject: assert property ( // [RULE8]
		(state_reg == hdsc_pkg::I2C_ADDR && sclFall && byteDone &&
		!startSeen && !stopSeen && shift_reg[7:1] != ownAddr)
		|=> (state_reg == hdsc_pkg::I2C_IDLE && !sdaPullLow))
		else $error("foreign address was acknowledged");
	a_burst_advance: assert property ( // [RULE13]
		wrEn_reg |-> (idx_reg == wrIdx_reg + 8'h01 &&
		$past(state_reg) == hdsc_pkg::I2C_WDATA))
		else $error("write did not follow sub-address or advance");
endmodule
`default_nettype wire

// [hdl/hdsc_pkg.sv]
// shared constants and types of the headset detect switch control
package hdsc_pkg;
	// register indexes; byte address on the bus is four times the index
	localparam logic [7:0] IDX_MODE = 8'h00;
	localparam logic [7:0] IDX_SWITCH = 8'h01;
	localparam logic [7:0] IDX_AUX = 8'h02;
	localparam logic [7:0] IDX_RESULT = 8'h03;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h04;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h05;
	localparam logic [7:0] REG_COUNT = 8'h06;
	// auxiliary control fields
	localparam int AUX_DET_START = 0;
	localparam int AUX_AUTO_DIS = 1;
	localparam int AUX_ROLE_LSB = 2;
	localparam int AUX_MANUAL_PULL = 4;
	// interrupt status and mask fields
	localparam int IRQ_DET_DONE = 0;
	localparam int IRQ_MIC_DET = 1;
	// reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [5:0] SWITCH_RST = 6'h00;
	localparam logic [1:0] MASK_RST = 2'h0;
	// switch mode codes
	localparam logic [2:0] MODE_ISOLATE = 3'h0;
	localparam logic [2:0] MODE_MIC_RING2 = 3'h2;
	localparam logic [2:0] MODE_MIC_SLEEVE = 3'h3;
	localparam logic [2:0] MODE_GND_SHORT = 3'h4;
	localparam logic [2:0] MODE_RING2_ONLY = 3'h5;
	localparam logic [2:0] MODE_SLEEVE_ONLY = 3'h6;
	localparam logic [2:0] MODE_PER_SWITCH = 3'h7;
	// switch enables: b0 mic-sleeve, b1 mic-ring2, b2 gnd-sleeve,
	// b3 gnd-ring2, b4 short sleeve, b5 short ring2
	localparam logic [5:0] ROUTE_MIC_RING2 = 6'h06;
	localparam logic [5:0] ROUTE_MIC_SLEEVE = 6'h09;
	localparam logic [5:0] ROUTE_GND_SHORT = 6'h30;
	localparam logic [5:0] ROUTE_RING2_ONLY = 6'h02;
	localparam logic [5:0] ROUTE_SLEEVE_ONLY = 6'h01;
	// presence pin roles
	localparam logic [1:0] ROLE_PRESENT = 2'h0;
	localparam logic [1:0] ROLE_IRQ = 2'h1;
	localparam logic [1:0] ROLE_OFF = 2'h2;
	// serial write address bytes per strap level
	localparam logic [7:0] I2C_WR_STRAP_LOW = 8'h76;
	localparam logic [7:0] I2C_WR_STRAP_HIGH = 8'h78;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int DET_TIME_MS = 500;
	localparam int DET_CYCLES = DET_TIME_MS * (CLK_FREQ_HZ / 1000);
	// pin synchroniser lanes
	localparam int SYNC_W = 7;
	localparam int SYN_SCL = 0;
	localparam int SYN_SDA = 1;
	localparam int SYN_ADDR = 2;
	localparam int SYN_TRIG = 3;
	localparam int SYN_SLEEVE = 4;
	localparam int SYN_RING2 = 5;
	localparam int SYN_PIN = 6;
	localparam logic [6:0] SYNC_RST = 7'h03;
	typedef enum logic {DET_IDLE, DET_RUN} hdsc_det_state_type;
	typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_SUB, I2C_WDATA,
		I2C_ACK, I2C_RDATA, I2C_MACK} hdsc_i2c_state_type;
endpackage

// [hdl/hdsc_reg_if.sv]
// register access carrier between the serial slave and the register file
`timescale 1ns/1ps
`default_nettype none
interface hdsc_reg_if;
	logic wrEn;
	logic [7:0] wrIdx;
	logic [7:0] wrData;
	logic [7:0] rdIdx;
	logic [7:0] rdData;
	modport master (output wrEn, output wrIdx, output wrData, output rdIdx,
		input rdData);
	modport regs (input wrEn, input wrIdx, input wrData, input rdIdx,
		output rdData);
endinterface
`default_nettype wire

// [hdl/hdsc_switch_ctrl.sv]
// headset detection, jack switch routing and register file
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RULE1] detection starts on a serial or bus command, or on the trigger pin
// [RULE2] a rising edge of the trigger pin starts detection
// [RULE3] after detection the mic line goes to the contact carrying the mic
// [RULE4] the mic ground goes to the contact found as ground
// [RULE5] software can disable auto routing; switches then stay untouched
// [RULE6] every switch can be set directly from registers
// [RULE7] the presence pin is pulled low when detection finds a mic
// [RULE8] strap low answers 8'h76/8'h77, strap high 8'h78/8'h79
// [RULE9] reset register values give pin-only operation
// [RULE10] presence stays low until the next detection completes
// [RULE11] with auto routing off the mode stays at isolation '000'
// [RULE12] presence pin role: presence, interrupt or disabled
// [RULE13] sub-address first, bursts advance, read-only writes ignored
// [RULE14] detection completes within 500 ms; result only after completion
module hdsc_switch_ctrl #(
	parameter int DET_CYCLES = hdsc_pkg::DET_CYCLES,
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	input wire logic addrSelIn,
	input wire logic detectionTriggerInput,
	input wire logic sleeveMicSense,
	input wire logic ring2MicSense,
	input wire logic micPresentIn,
	output logic micPresentOut,
	output logic micPresentOeN,
	output logic [5:0] switchEnable,
	output logic irq,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	localparam int CNT_W = $clog2(DET_CYCLES + 1);

	// parameter sanity at elaboration
	if (DET_CYCLES < 2) begin : g_bad_cycles
		$error("DET_CYCLES must be at least 2");
	end
	if (ADDR_W < 5 || ADDR_W > 10) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 10");
	end

	logic [hdsc_pkg::SYNC_W-1:0] rawIn;
	logic [hdsc_pkg::SYNC_W-1:0] syncA_reg;
	logic [hdsc_pkg::SYNC_W-1:0] syncB_reg;
	logic [hdsc_pkg::SYNC_W-1:0] syncC_reg;
	logic [hdsc_pkg::SYNC_W-1:0] filt_reg;
	logic [hdsc_pkg::SYNC_W-1:0] agree;
	logic trigPrev_reg;
	logic trigRise;
	logic [6:0] ownAddr;
	logic sdaPullLow;
	logic [2:0] switchModeField_reg;
	logic [5:0] perSwitchControl_reg;
	logic autoRoutingDisable_reg;
	logic [1:0] presenceRole_reg;
	logic manualPull_reg;
	logic [1:0] irqStatus_reg;
	logic [1:0] irqMask_reg;
	logic [1:0] irqClear;
	logic [1:0] irqSet;
	logic micFound_reg;
	logic micOnSleeve_reg;
	hdsc_pkg::hdsc_det_state_type detState_reg;
	logic [CNT_W-1:0] detCount_reg;
	logic detDone;
	logic detStartCmd;
	logic senseFound;
	logic modeWr;
	logic [5:0] switchEnable_reg;
	logic micPresentOeN_reg;
	logic pullLowNext;
	logic axiWrGo;
	logic axiWrMapped;
	logic axiRdMapped;
	logic [7:0] awIdx;
	logic [7:0] arIdx;
	logic wrEn;
	logic [7:0] wrIdx;
	logic [7:0] wrData;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;

	hdsc_reg_if regBus ();

	// register image as seen by either bus
	function automatic logic [7:0] readReg(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			hdsc_pkg::IDX_MODE: v = {5'h00, switchModeField_reg};
			hdsc_pkg::IDX_SWITCH: v = {2'h0, perSwitchControl_reg};
			hdsc_pkg::IDX_AUX: v = {3'h0, manualPull_reg, presenceRole_reg,
				autoRoutingDisable_reg, 1'b0};
			hdsc_pkg::IDX_RESULT: v = {4'h0, filt_reg[hdsc_pkg::SYN_PIN],
				(detState_reg == hdsc_pkg::DET_RUN), micOnSleeve_reg,
				micFound_reg};
			hdsc_pkg::IDX_IRQ_STATUS: v = {6'h00, irqStatus_reg};
			hdsc_pkg::IDX_IRQ_MASK: v = {6'h00, irqMask_reg};
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// preset routing table; code 001 and isolation open everything
	function automatic logic [5:0] routeOf(input logic [2:0] mode,
		input logic [5:0] each);
		logic [5:0] v;
		v = 6'h00;
		case (mode)
			hdsc_pkg::MODE_MIC_RING2: v = hdsc_pkg::ROUTE_MIC_RING2;
			hdsc_pkg::MODE_MIC_SLEEVE: v = hdsc_pkg::ROUTE_MIC_SLEEVE;
			hdsc_pkg::MODE_GND_SHORT: v = hdsc_pkg::ROUTE_GND_SHORT;
			hdsc_pkg::MODE_RING2_ONLY: v = hdsc_pkg::ROUTE_RING2_ONLY;
			hdsc_pkg::MODE_SLEEVE_ONLY: v = hdsc_pkg::ROUTE_SLEEVE_ONLY;
			hdsc_pkg::MODE_PER_SWITCH: v = each;
			default: v = 6'h00;
		endcase
		return v;
	endfunction

	// three-stage pin synchronisers; a change counts when stages 2 and 3 agree
	assign rawIn = {micPresentIn, ring2MicSense, sleeveMicSense,
		detectionTriggerInput, addrSelIn, sdaIn, sclIn};
	assign agree = ~(syncB_reg ^ syncC_reg);
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			syncA_reg <= hdsc_pkg::SYNC_RST;
			syncB_reg <= hdsc_pkg::SYNC_RST;
			syncC_reg <= hdsc_pkg::SYNC_RST;
			filt_reg <= hdsc_pkg::SYNC_RST;
			trigPrev_reg <= 1'b0;
		end else begin
			syncA_reg <= rawIn;
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
			filt_reg <= (agree & syncC_reg) | (~agree & filt_reg);
			trigPrev_reg <= filt_reg[hdsc_pkg::SYN_TRIG];
		end
	end

	// serial slave; address chosen by the strap level
	assign ownAddr = filt_reg[hdsc_pkg::SYN_ADDR] ?
		hdsc_pkg::I2C_WR_STRAP_HIGH[7:1] :
		hdsc_pkg::I2C_WR_STRAP_LOW[7:1]; // [RULE8]
	assign sdaOut = 1'b0;
	assign sdaOeN = ~sdaPullLow;
	hdsc_i2c_slave u_i2c (
		.clk(clk),
		.reset_n(reset_n),
		.sclLevel(filt_reg[hdsc_pkg::SYN_SCL]),
		.sdaLevel(filt_reg[hdsc_pkg::SYN_SDA]),
		.ownAddr(ownAddr),
		.sdaPullLow(sdaPullLow),
		.regPort(regBus.master)
	);
	always_comb begin
		regBus.rdData = readReg(regBus.rdIdx);
	end

	// one write port shared by both buses; the serial side has priority
	assign awIdx = 8'(awaddr[ADDR_W-1:2]);
	assign arIdx = 8'(araddr[ADDR_W-1:2]);
	assign axiWrMapped = (awaddr[1:0] == 2'h0) && (awIdx < hdsc_pkg::REG_COUNT);
	assign axiRdMapped = (araddr[1:0] == 2'h0) && (arIdx < hdsc_pkg::REG_COUNT);
	assign axiWrGo = awvalid & wvalid & ~bvalid_reg & ~regBus.wrEn;
	assign awready = axiWrGo;
	assign wready = axiWrGo;
	assign wrEn = regBus.wrEn | (axiWrGo & axiWrMapped & wstrb[0]);
	assign wrIdx = regBus.wrEn ? regBus.wrIdx : awIdx;
	assign wrData = regBus.wrEn ? regBus.wrData : wdata[7:0];
	assign modeWr = wrEn && (wrIdx == hdsc_pkg::IDX_MODE);
	assign detStartCmd = wrEn && (wrIdx == hdsc_pkg::IDX_AUX) &&
		wrData[hdsc_pkg::AUX_DET_START]; // [RULE1]

	// write response; unmapped addresses answer slave error
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= hdsc_pkg::RESP_OKAY;
		end else if (axiWrGo) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= axiWrMapped ? hdsc_pkg::RESP_OKAY :
				hdsc_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;

	// read channel; data registered one cycle after the address
	assign arready = arvalid & ~rvalid_reg;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rvalid_reg <= 1'b0;
			rresp_reg <= hdsc_pkg::RESP_OKAY;
			rdata_reg <= 32'h00000000;
		end else if (arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= axiRdMapped ? hdsc_pkg::RESP_OKAY :
				hdsc_pkg::RESP_SLVERR;
			rdata_reg <= {24'h000000, readReg(arIdx)};
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = rdata_reg;

	// detection sequencer; a fixed window, result latched at its end
	assign trigRise = filt_reg[hdsc_pkg::SYN_TRIG] & ~trigPrev_reg; // [RULE2]
	assign detDone = (detState_reg == hdsc_pkg::DET_RUN) &&
		(detCount_reg == CNT_W'(DET_CYCLES - 1)); // [RULE14]
	assign senseFound = filt_reg[hdsc_pkg::SYN_SLEEVE] |
		filt_reg[hdsc_pkg::SYN_RING2];
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			detState_reg <= hdsc_pkg::DET_IDLE;
			detCount_reg <= '0;
		end else begin
			unique case (detState_reg)
				hdsc_pkg::DET_IDLE: begin
					if (trigRise || detStartCmd) begin // [RULE1]
						detState_reg <= hdsc_pkg::DET_RUN;
						detCount_reg <= '0;
					end
				end
				hdsc_pkg::DET_RUN: begin
					if (detDone) begin
						detState_reg <= hdsc_pkg::DET_IDLE;
					end else begin
						detCount_reg <= detCount_reg + 1'b1;
					end
				end
			endcase
		end
	end

	// result held until the next sequence completes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			micFound_reg <= 1'b0;
			micOnSleeve_reg <= 1'b0;
		end else if (detDone) begin // [RULE10]
			micFound_reg <= senseFound;
			micOnSleeve_reg <= filt_reg[hdsc_pkg::SYN_SLEEVE];
		end
	end

	// switch mode; auto routing overrides a same-cycle software write
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			switchModeField_reg <= hdsc_pkg::MODE_RST;
		end else if (detDone && !autoRoutingDisable_reg && senseFound) begin
			switchModeField_reg <= filt_reg[hdsc_pkg::SYN_SLEEVE] ?
				hdsc_pkg::MODE_MIC_SLEEVE :
				hdsc_pkg::MODE_MIC_RING2; // [RULE3] [RULE4] [RULE5] [RULE11]
		end else if (modeWr) begin
			switchModeField_reg <= wrData[2:0]; // [RULE6]
		end
	end

	// software-only control registers; result and other indexes read-only
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			perSwitchControl_reg <= hdsc_pkg::SWITCH_RST;
			autoRoutingDisable_reg <= 1'b0; // [RULE9]
			presenceRole_reg <= hdsc_pkg::ROLE_PRESENT; // [RULE9]
			manualPull_reg <= 1'b0;
			irqMask_reg <= hdsc_pkg::MASK_RST;
		end else if (wrEn) begin
			if (wrIdx == hdsc_pkg::IDX_SWITCH) begin
				perSwitchControl_reg <= wrData[5:0]; // [RULE6]
			end
			if (wrIdx == hdsc_pkg::IDX_AUX) begin
				autoRoutingDisable_reg <= wrData[hdsc_pkg::AUX_AUTO_DIS];
				presenceRole_reg <= wrData[hdsc_pkg::AUX_ROLE_LSB +: 2];
				manualPull_reg <= wrData[hdsc_pkg::AUX_MANUAL_PULL];
			end
			if (wrIdx == hdsc_pkg::IDX_IRQ_MASK) begin
				irqMask_reg <= wrData[1:0];
			end
		end
	end

	// sticky events, write one to clear, a new event wins over the clear
	assign irqSet = {detDone & senseFound, detDone};
	assign irqClear = (wrEn && wrIdx == hdsc_pkg::IDX_IRQ_STATUS) ?
		wrData[1:0] : 2'h0;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irqStatus_reg <= 2'h0;
		end else begin
			irqStatus_reg <= irqSet | (irqStatus_reg & ~irqClear);
		end
	end
	assign irq = |(irqStatus_reg & irqMask_reg);

	// presence pin role and switch drive, both from flip-flops
	assign pullLowNext = manualPull_reg |
		(presenceRole_reg == hdsc_pkg::ROLE_PRESENT && micFound_reg) |
		(presenceRole_reg == hdsc_pkg::ROLE_IRQ &&
		irqStatus_reg[hdsc_pkg::IRQ_MIC_DET]); // [RULE7] [RULE12]
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			micPresentOeN_reg <= 1'b1;
			switchEnable_reg <= 6'h00;
		end else begin
			micPresentOeN_reg <= ~pullLowNext;
			switchEnable_reg <= routeOf(switchModeField_reg,
				perSwitchControl_reg); // [RULE6]
		end
	end
	assign micPresentOut = 1'b0;
	assign micPresentOeN = micPresentOeN_reg;
	assign switchEnable = switchEnable_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_trigger_start: assert property ( // [RULE2]
		(detState_reg == hdsc_pkg::DET_IDLE && trigRise)
		|=> (detState_reg == hdsc_pkg::DET_RUN && detCount_reg == '0))
		else $error("trigger edge did not start detection");
	a_command_start: assert property ( // [RULE1]
		(detState_reg == hdsc_pkg::DET_IDLE && detStartCmd)
		|=> detState_reg == hdsc_pkg::DET_RUN)
		else $error("start command did not start detection");
	a_route_sleeve: assert property ( // [RULE3]
		(detDone && !autoRoutingDisable_reg &&
		filt_reg[hdsc_pkg::SYN_SLEEVE])
		|=> ##1 switchEnable == hdsc_pkg::ROUTE_MIC_SLEEVE)
		else $error("mic not routed to sleeve");
	a_route_ring2: assert property ( // [RULE4]
		(detDone && !autoRoutingDisable_reg &&
		!filt_reg[hdsc_pkg::SYN_SLEEVE] && filt_reg[hdsc_pkg::SYN_RING2])
		|=> ##1 (switchEnable == hdsc_pkg::ROUTE_MIC_RING2))
		else $error("mic and ground not routed for ring2");
	a_auto_off: assert property ( // [RULE5]
		(detDone && autoRoutingDisable_reg && !modeWr)
		|=> $stable(switchModeField_reg))
		else $error("mode changed with auto routing off");
	a_isolate_kept: assert property ( // [RULE11]
		(detDone && autoRoutingDisable_reg && !modeWr &&
		switchModeField_reg == hdsc_pkg::MODE_ISOLATE)
		|=> ##1 switchEnable == 6'h00)
		else $error("isolation left after detection");
	a_per_switch: assert property ( // [RULE6]
		(switchModeField_reg == hdsc_pkg::MODE_PER_SWITCH)
		|=> switchEnable == $past(perSwitchControl_reg))
		else $error("per-switch bits not applied");
	a_present_low: assert property ( // [RULE7]
		(presenceRole_reg == hdsc_pkg::ROLE_PRESENT && micFound_reg)
		|=> !micPresentOeN)
		else $error("presence pin not pulled low");
	a_present_hold: assert property ( // [RULE10]
		(micFound_reg && !detDone) |=> micFound_reg)
		else $error("presence result dropped before completion");
	a_role_off: assert property ( // [RULE12]
		(presenceRole_reg == hdsc_pkg::ROLE_OFF && !manualPull_reg)
		|=> micPresentOeN)
		else $error("disabled presence pin was driven");
	a_det_bound: assert property ( // [RULE14]
		(detState_reg == hdsc_pkg::DET_RUN && !detDone)
		|=> ($stable(micFound_reg) && detCount_reg < CNT_W'(DET_CYCLES)))
		else $error("result changed early or window overran");
endmodule
`default_nettype wire

// [tb/hdsc_pin_partner.sv]
// pin partner: pulled-up serial lines with a host, strap, trigger, senses
`timescale 1ns/1ps
`default_nettype none
module hdsc_pin_partner (
	input wire logic sdaOeN,
	input wire logic micPresentOeN,
	input wire logic fire,
	input wire logic [1:0] sense,
	input wire logic hostScl,
	input wire logic hostSda,
	output logic sclIn,
	output logic sdaIn,
	output logic addrSelIn,
	output logic detectionTriggerInput,
	output logic sleeveMicSense,
	output logic ring2MicSense,
	output logic micPresentIn
);
	// idle host lines sit high on their pull-ups; data is a wired and
	assign sclIn = hostScl;
	assign sdaIn = hostSda & sdaOeN;
	assign addrSelIn = 1'b0;
	// outside logic raises the trigger pin to ask for a detection
	assign detectionTriggerInput = fire;
	// jack sense levels and the pulled-up presence pin
	assign sleeveMicSense = sense[0];
	assign ring2MicSense = sense[1];
	assign micPresentIn = micPresentOeN;
endmodule
`default_nettype wire

// [tb/headset_detect_switch_control_tb.sv]
// self-checking bench of the headset detect switch control
`timescale 1ns/1ps
`default_nettype none
module headset_detect_switch_control_tb;
	logic clk = 1'b0, reset_n = 1'b0, fire = 1'b0;
	logic [1:0] sense = 2'h0;
	logic sclIn, sdaIn, sdaOut, sdaOeN, addrSelIn, detectionTriggerInput;
	logic sleeveMicSense, ring2MicSense, micPresentIn, micPresentOut;
	logic micPresentOeN, irq, awready, wready, bvalid, arready, rvalid;
	logic [5:0] switchEnable;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, rd, wdata = 32'h0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic hostScl = 1'b1, hostSda = 1'b1, ack;
	int miscompares = 0, compares = 0;
	// clock of 100 ns period
	always #50 clk = ~clk;
	hdsc_pin_partner u_partner (.sdaOeN, .micPresentOeN, .fire, .sense,
		.hostScl, .hostSda,
		.sclIn, .sdaIn, .addrSelIn, .detectionTriggerInput, .sleeveMicSense,
		.ring2MicSense, .micPresentIn);
	hdsc_switch_ctrl #(.DET_CYCLES(20)) u_dut (.clk, .reset_n, .sclIn,
		.sdaIn, .sdaOut, .sdaOeN, .addrSelIn, .detectionTriggerInput,
		.sleeveMicSense, .ring2MicSense, .micPresentIn, .micPresentOut,
		.micPresentOeN, .switchEnable, .irq, .awaddr, .awvalid, .awready,
		.wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	task close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] seen, input logic [31:0] e);
		compares++;
		if (seen !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, e, seen);
		end
	endtask
	// wait for a handshake flag high at a rising edge, bounded
	task hold(input int which);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		while (!ok) begin
			@(negedge clk);
			ok = which == 0 ? awready && wready : which == 1 ? bvalid :
				which == 2 ? arready : rvalid;
			@(posedge clk);
			if (++n > 100) begin
				miscompares++;
				close_out();
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		hold(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		hold(1);
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(r));
		@(posedge clk); // let the written state reach the outputs
	endtask
	task rdRaw(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		hold(2);
		arvalid <= 1'b0;
		rready <= 1'b1;
		hold(3);
		rready <= 1'b0;
		rd = rdata;
	endtask
	task rdr(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
		rdRaw(a);
		chk("rdata", rd, 32'(e));
		chk("rresp", 32'(rresp), 32'(r));
	endtask
	// poll the busy bit until the detection window has closed
	task waitDet();
		int n;
		n = 0;
		repeat (8) @(posedge clk);
		rd = 32'h4;
		while (rd[2] !== 1'b0) begin
			rdRaw(8'h0C);
			if (++n > 60) begin
				miscompares++;
				close_out();
			end
		end
	endtask
	// serial host bit: clock low, data, clock high; ends with clock high
	task i2cBit(input logic b);
		hostScl <= 1'b0;
		repeat (5) @(posedge clk);
		hostSda <= b;
		repeat (10) @(posedge clk);
		hostScl <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
	// byte msb first, then a released ack bit sampled while clock is high
	task i2cByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			i2cBit(b[i]);
		end
		i2cBit(1'b1);
		ack = ~sdaIn;
	endtask
	// start, address, sub-address, two burst data bytes, stop
	task i2cWr(input logic [7:0] a, input logic [7:0] x,
		input logic [7:0] d0, input logic [7:0] d1, input logic e);
		hostSda <= 1'b0;
		repeat (10) @(posedge clk);
		i2cByte(a);
		chk("ack", 32'(ack), 32'(e));
		i2cByte(x);
		i2cByte(d0);
		i2cByte(d1);
		i2cBit(1'b0);
		hostSda <= 1'b1;
		repeat (10) @(posedge clk);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("switch", 32'(switchEnable), 32'h0);
		chk("pin", 32'(micPresentIn), 32'h1);
		chk("sda", 32'(sdaIn), 32'h1);
		rdr(8'h00, 8'h00, 2'h0);
		rdr(8'h08, 8'h00, 2'h0);
		rdr(8'h18, 8'h00, 2'h2);
		wr(8'h18, 32'h1, 2'h2);
		$display("test reset done");
		sense <= 2'h1;
		fire <= 1'b1;
		waitDet();
		chk("switch", 32'(switchEnable), 32'h09);
		chk("pin", 32'(micPresentIn), 32'h0);
		chk("drive", 32'({sdaOut, micPresentOut}), 32'h0);
		rdr(8'h00, 8'h03, 2'h0);
		rdr(8'h0C, 8'h03, 2'h0);
		$display("test pin trigger done");
		fire <= 1'b0;
		sense <= 2'h2;
		wr(8'h10, 32'h3, 2'h0);
		wr(8'h14, 32'h3, 2'h0);
		wr(8'h08, 32'h1, 2'h0);
		waitDet();
		chk("switch", 32'(switchEnable), 32'h06);
		chk("pin", 32'(micPresentIn), 32'h0);
		chk("irq", 32'(irq), 32'h1);
		wr(8'h10, 32'h3, 2'h0);
		chk("irq", 32'(irq), 32'h0);
		$display("test command done");
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h08, 32'h3, 2'h0);
		waitDet();
		rdr(8'h00, 8'h00, 2'h0);
		chk("switch", 32'(switchEnable), 32'h0);
		wr(8'h0C, 32'hFF, 2'h0);
		rdr(8'h0C, 8'h01, 2'h0);
		wr(8'h08, 32'h0A, 2'h0);
		repeat (6) @(posedge clk);
		chk("pin", 32'(micPresentIn), 32'h1);
		wr(8'h08, 32'h06, 2'h0);
		chk("pin", 32'(micPresentIn), 32'h0);
		$display("test auto off done");
		wr(8'h00, 32'h7, 2'h0);
		wr(8'h04, 32'h2A, 2'h0);
		chk("switch", 32'(switchEnable), 32'h2A);
		wr(8'h00, 32'h4, 2'h0);
		chk("switch", 32'(switchEnable), 32'h30);
		$display("test manual done");
		i2cWr(8'h76, 8'h01, 8'h15, 8'h02, 1'b1);
		rdr(8'h04, 8'h15, 2'h0);
		rdr(8'h08, 8'h02, 2'h0);
		i2cWr(8'h78, 8'h01, 8'h33, 8'h00, 1'b0);
		rdr(8'h04, 8'h15, 2'h0);
		$display("test serial done");
		close_out();
	end
endmodule
`default_nettype wire
